// File: design/pss_power_state_ctrl.sv
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
module pss_power_state_ctrl (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire pss_pkg::pss_reg_req_t reg_req_i,
  output logic [31:0] reg_rdata_o,
  input wire logic sleep_req_i,
  input wire logic wake_req_i,
  input wire logic [31:0] asleep_cfg_i,
  input wire logic [31:0] wake1_cfg_i,
  input wire logic [31:0] wake2_cfg_i,
  input wire pss_pkg::pss_good_t supply_good_i,
  output pss_pkg::pss_supply_t supply_ctrl_o,
  output logic [2:0] state_code_o
);

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [31:0] awake_q;
  logic [31:0] slp1_q;
  logic [31:0] slp2_q;
  logic [31:0] rdata_q;
  logic wr_awake;
  logic wr_slp1;
  logic wr_slp2;
  logic [31:0] wdata;

  assign wdata = reg_req_i.wdata;
  assign wr_awake = reg_req_i.wr && (reg_req_i.addr == pss_pkg::AWAKE_OFS);
  assign wr_slp1 = reg_req_i.wr && (reg_req_i.addr == pss_pkg::SLP1_OFS);
  assign wr_slp2 = reg_req_i.wr && (reg_req_i.addr == pss_pkg::SLP2_OFS);

  // the analogue enable is left out of the write masks so it holds
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      awake_q <= pss_pkg::AWAKE_RST;
    end else if (wr_awake) begin
      awake_q <= (awake_q & ~pss_pkg::CFG_RW_MASK)
               | (wdata & pss_pkg::CFG_RW_MASK);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      slp1_q <= pss_pkg::SLP1_RST;
    end else if (wr_slp1) begin
      slp1_q <= (slp1_q & ~(pss_pkg::CFG_RW_MASK | pss_pkg::DWELL_MASK))
              | (wdata & (pss_pkg::CFG_RW_MASK | pss_pkg::DWELL_MASK));
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      slp2_q <= pss_pkg::SLP2_RST;
    end else if (wr_slp2) begin
      slp2_q <= (slp2_q & ~(pss_pkg::CFG_RW_MASK | pss_pkg::DWELL_MASK))
              | (wdata & (pss_pkg::CFG_RW_MASK | pss_pkg::DWELL_MASK));
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  pss_pkg::pss_state_t state_q;
  pss_pkg::pss_state_t state_d;
  pss_pkg::pss_supply_t applied_q;
  logic [3:0] prev_q;
  logic [31:0] dwell_cnt_q;
  logic [31:0] cur_word;
  logic [31:0] next_word;
  logic [31:0] dwell_lim;
  logic [4:0] dwell_n;
  logic expired;
  logic good_ok;
  logic leave_ok;

  // settings word that governs a given state
  function automatic logic [31:0] word_of(pss_pkg::pss_state_t s,
                                          logic [31:0] aw,
                                          logic [31:0] s1,
                                          logic [31:0] s2,
                                          logic [31:0] asl,
                                          logic [31:0] w1,
                                          logic [31:0] w2);
    logic [31:0] w;
    case (s)
      pss_pkg::ST_AWAKE: w = aw;
      pss_pkg::ST_AWAKE_WAIT: w = aw;
      pss_pkg::ST_SLEEP1: w = s1;
      pss_pkg::ST_SLEEP2: w = s2;
      pss_pkg::ST_ASLEEP: w = asl;
      pss_pkg::ST_WAKE1: w = w1;
      pss_pkg::ST_WAKE2: w = w2;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  assign cur_word = word_of(state_q, awake_q, slp1_q, slp2_q,
                            asleep_cfg_i, wake1_cfg_i, wake2_cfg_i);
  assign next_word = word_of(state_d, awake_q, slp1_q, slp2_q,
                             asleep_cfg_i, wake1_cfg_i, wake2_cfg_i);

  assign dwell_n = cur_word[pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W];
  // 2^N cycles in the state means the count ends at 2^N - 1
  assign dwell_lim = (32'h0000_0001 << dwell_n) - 32'h0000_0001;
  // >= so that a shortened dwell written mid-state still releases
  assign expired = (dwell_cnt_q >= dwell_lim);

  // a supply that is off in this state does not hold the sequencer
  assign good_ok = (!applied_q.core_en || supply_good_i.core_good)
                && (!applied_q.analog_en || supply_good_i.analog_good)
                && (!applied_q.pll_en || supply_good_i.pll_good)
                && (!applied_q.io_en || supply_good_i.io_good);
  assign leave_ok = expired && good_ok;

  always_comb begin
    state_d = state_q;
    case (state_q)
      pss_pkg::ST_RESET: begin
        state_d = pss_pkg::ST_AWAKE_WAIT;
      end
      pss_pkg::ST_AWAKE_WAIT: begin
        if (good_ok) begin
          state_d = pss_pkg::ST_AWAKE;
        end
      end
      pss_pkg::ST_AWAKE: begin
        if (sleep_req_i) begin
          state_d = pss_pkg::ST_SLEEP1;
        end
      end
      pss_pkg::ST_SLEEP1: begin
        if (leave_ok) begin
          state_d = pss_pkg::ST_SLEEP2;
        end
      end
      pss_pkg::ST_SLEEP2: begin
        if (leave_ok) begin
          state_d = pss_pkg::ST_ASLEEP;
        end
      end
      pss_pkg::ST_ASLEEP: begin
        if (wake_req_i) begin
          state_d = pss_pkg::ST_WAKE1;
        end
      end
      pss_pkg::ST_WAKE1: begin
        if (leave_ok) begin
          state_d = pss_pkg::ST_WAKE2;
        end
      end
      pss_pkg::ST_WAKE2: begin
        if (leave_ok) begin
          state_d = pss_pkg::ST_AWAKE_WAIT;
        end
      end
      default: begin
        state_d = pss_pkg::ST_RESET;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      state_q <= pss_pkg::ST_RESET;
    end else begin
      state_q <= state_d;
    end
  end

  // settings load on the same edge as the state, from the next state
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      applied_q <= '0;
    end else begin
      applied_q <= pss_pkg::cfg_to_supply(next_word);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      prev_q <= pss_pkg::PREV_RST;
    end else if (state_d != state_q) begin
      prev_q <= {applied_q.io_en, applied_q.pll_en,
                 applied_q.analog_en, applied_q.core_en};
    end
  end

  // counter saturates so a 2^31 dwell never wraps
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      dwell_cnt_q <= 32'h0000_0000;
    end else if (state_d != state_q) begin
      dwell_cnt_q <= 32'h0000_0000;
    end else if (!expired) begin
      dwell_cnt_q <= dwell_cnt_q + 32'h0000_0001;
    end
  end

  // ----------------------------------------------------------------
  // status and read port
  // ----------------------------------------------------------------
  logic [31:0] status_word;

  always_comb begin
    status_word = pss_pkg::supply_to_word(applied_q);
    status_word[pss_pkg::STATE_LSB +: 3] = pss_pkg::state_code(state_q);
    status_word[pss_pkg::PREV_IO_BIT] = prev_q[3];
    status_word[pss_pkg::PREV_PLL_BIT] = prev_q[2];
    status_word[pss_pkg::PREV_ANA_BIT] = prev_q[1];
    status_word[pss_pkg::PREV_CORE_BIT] = prev_q[0];
  end

  // unmapped offsets read as zero
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (!reg_req_i.rd) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_req_i.addr == pss_pkg::AWAKE_OFS) begin
      rdata_q <= awake_q;
    end else if (reg_req_i.addr == pss_pkg::SLP1_OFS) begin
      rdata_q <= slp1_q;
    end else if (reg_req_i.addr == pss_pkg::SLP2_OFS) begin
      rdata_q <= slp2_q;
    end else if (reg_req_i.addr == pss_pkg::STAT_OFS) begin
      rdata_q <= status_word;
    end else begin
      rdata_q <= 32'h0000_0000;
    end
  end

  assign reg_rdata_o = rdata_q;
  assign supply_ctrl_o = applied_q;
  assign state_code_o = pss_pkg::state_code(state_q);

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // stay_q counts cycles in the current state apart from the sequencer's
  // own counter, so the dwell checks do not lean on it
  logic [31:0] stay_q;
  logic [31:0] slp1_lim;
  logic [31:0] slp2_lim;

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      stay_q <= 32'h0000_0000;
    end else if (state_d != state_q) begin
      stay_q <= 32'h0000_0000;
    end else if (stay_q != 32'hFFFF_FFFF) begin
      stay_q <= stay_q + 32'h0000_0001;
    end
  end

  assign slp1_lim = (32'h0000_0001
                     << slp1_q[pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W])
                    - 32'h0000_0001;
  assign slp2_lim = (32'h0000_0001
                     << slp2_q[pss_pkg::DWELL_LSB +: pss_pkg::DWELL_W])
                    - 32'h0000_0001;

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_awake_apply: assert property (
    state_q == pss_pkg::ST_AWAKE && $past(resetn_i)
    |-> applied_q == pss_pkg::cfg_to_supply($past(awake_q)))
    else $error("awake settings not applied");

  chk_sleep1_apply: assert property (
    state_q == pss_pkg::ST_SLEEP1 && $past(resetn_i)
    |-> applied_q == pss_pkg::cfg_to_supply($past(slp1_q)))
    else $error("first sleep settings not applied");

  chk_sleep2_apply: assert property (
    state_q == pss_pkg::ST_SLEEP2 && $past(resetn_i)
    |-> applied_q == pss_pkg::cfg_to_supply($past(slp2_q)))
    else $error("second sleep settings not applied");

  chk_dwell_length: assert property (
    state_q == pss_pkg::ST_SLEEP1 && state_d != pss_pkg::ST_SLEEP1
    |-> stay_q >= slp1_lim)
    else $error("first sleep left before dwell expired");

  chk_sleep2_dwell: assert property (
    state_q == pss_pkg::ST_SLEEP2 && state_d != pss_pkg::ST_SLEEP2
    |-> stay_q >= slp2_lim)
    else $error("second sleep left before dwell expired");

  chk_tile_gate: assert property (
    state_q == pss_pkg::ST_ASLEEP && $past(resetn_i)
    |-> supply_ctrl_o.tile_clk_off
        == $past(asleep_cfg_i[pss_pkg::TILE_OFF_BIT]))
    else $error("tile clock gate wrong while asleep");

  chk_analog_ro: assert property (
    wr_awake |=> awake_q[pss_pkg::ANA_EN_BIT]
                 == $past(awake_q[pss_pkg::ANA_EN_BIT]))
    else $error("analogue enable altered by write");

  chk_state_read: assert property (
    reg_req_i.rd && reg_req_i.addr == pss_pkg::STAT_OFS
    |=> rdata_q[pss_pkg::STATE_LSB +: 3] == $past(state_code_o))
    else $error("status state code wrong");

  chk_prev_enables: assert property (
    state_d != state_q |=> prev_q[0] == $past(applied_q.core_en)
                          && prev_q[3] == $past(applied_q.io_en))
    else $error("previous enables not captured");

  chk_sleep_order: assert property (
    state_q == pss_pkg::ST_SLEEP2 && stay_q >= slp2_lim && good_ok
    |=> state_q == pss_pkg::ST_ASLEEP)
    else $error("sleep phases out of order");

  chk_dwell_release: assert property (
    state_q == pss_pkg::ST_SLEEP1 && stay_q >= slp1_lim && good_ok
    |=> state_q == pss_pkg::ST_SLEEP2)
    else $error("first sleep held past its dwell");

  chk_wake_apply: assert property (
    state_q == pss_pkg::ST_WAKE1 && $past(resetn_i)
    |-> applied_q == pss_pkg::cfg_to_supply($past(wake1_cfg_i)))
    else $error("first wake settings not applied");

  chk_awake_reset: assert property (
    $rose(resetn_i) |-> awake_q == pss_pkg::AWAKE_RST)
    else $error("awake register reset value wrong");

  chk_sleep1_reset: assert property (
    $rose(resetn_i) |-> slp1_q == pss_pkg::SLP1_RST)
    else $error("first sleep register reset value wrong");

  chk_sleep2_reset: assert property (
    $rose(resetn_i) |-> slp2_q == pss_pkg::SLP2_RST)
    else $error("second sleep register reset value wrong");

  chk_prev_reset: assert property (
    $rose(resetn_i) |-> prev_q == pss_pkg::PREV_RST)
    else $error("previous enables reset value wrong");

  cov_sleep_entry: cover property (
    state_q == pss_pkg::ST_AWAKE ##1 state_q == pss_pkg::ST_SLEEP1);
  cov_asleep: cover property (
    state_q == pss_pkg::ST_SLEEP2 ##1 state_q == pss_pkg::ST_ASLEEP);
  cov_wake: cover property (
    state_q == pss_pkg::ST_WAKE2 ##1 state_q == pss_pkg::ST_AWAKE_WAIT);
  cov_wait_settle: cover property (
    state_q == pss_pkg::ST_AWAKE_WAIT ##1 state_q == pss_pkg::ST_AWAKE_WAIT);
  cov_status_read: cover property (
    reg_req_i.rd && reg_req_i.addr == pss_pkg::STAT_OFS);

endmodule

// File: design/pss_pkg.sv
package pss_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] AWAKE_OFS = 8'h18;
  localparam logic [7:0] SLP1_OFS = 8'h1C;
  localparam logic [7:0] SLP2_OFS = 8'h20;
  localparam logic [7:0] STAT_OFS = 8'h24;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CORE_EN_BIT = 0;
  localparam int ANA_EN_BIT = 1;
  localparam int PLL_EN_BIT = 4;
  localparam int IO_EN_BIT = 5;
  localparam int CORE_PFM_BIT = 8;
  localparam int ANA_PFM_BIT = 9;
  localparam int TILE_OFF_BIT = 14;
  localparam int DWELL_LSB = 16;
  localparam int DWELL_W = 5;
  localparam int STATE_LSB = 16;
  localparam int PREV_CORE_BIT = 24;
  localparam int PREV_ANA_BIT = 25;
  localparam int PREV_PLL_BIT = 28;
  localparam int PREV_IO_BIT = 29;

  // software-writable bits; analogue enable is kept read-only
  localparam logic [31:0] CFG_RW_MASK = 32'h0000_4331;
  localparam logic [31:0] DWELL_MASK = 32'h001F_0000;

  // ----------------------------------------------------------------
  // values after reset
  // ----------------------------------------------------------------
  localparam logic [31:0] AWAKE_RST = 32'h0000_0033;
  localparam logic [31:0] SLP1_RST = 32'h0010_0022;
  localparam logic [31:0] SLP2_RST = 32'h0010_0002;
  // order io, pll, analogue, core
  localparam logic [3:0] PREV_RST = 4'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic tile_clk_off;
    logic analog_pfm;
    logic core_pfm;
    logic io_en;
    logic pll_en;
    logic analog_en;
    logic core_en;
  } pss_supply_t;

  typedef struct packed {
    logic io_good;
    logic pll_good;
    logic analog_good;
    logic core_good;
  } pss_good_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } pss_reg_req_t;

  typedef enum logic [7:0] {
    ST_RESET = 8'h01,
    ST_ASLEEP = 8'h02,
    ST_WAKE1 = 8'h04,
    ST_WAKE2 = 8'h08,
    ST_AWAKE_WAIT = 8'h10,
    ST_AWAKE = 8'h20,
    ST_SLEEP1 = 8'h40,
    ST_SLEEP2 = 8'h80
  } pss_state_t;

  function automatic pss_supply_t cfg_to_supply(logic [31:0] w);
    pss_supply_t s;
    s.tile_clk_off = w[TILE_OFF_BIT];
    s.analog_pfm = w[ANA_PFM_BIT];
    s.core_pfm = w[CORE_PFM_BIT];
    s.io_en = w[IO_EN_BIT];
    s.pll_en = w[PLL_EN_BIT];
    s.analog_en = w[ANA_EN_BIT];
    s.core_en = w[CORE_EN_BIT];
    return s;
  endfunction

  function automatic logic [31:0] supply_to_word(pss_supply_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[TILE_OFF_BIT] = s.tile_clk_off;
    w[ANA_PFM_BIT] = s.analog_pfm;
    w[CORE_PFM_BIT] = s.core_pfm;
    w[IO_EN_BIT] = s.io_en;
    w[PLL_EN_BIT] = s.pll_en;
    w[ANA_EN_BIT] = s.analog_en;
    w[CORE_EN_BIT] = s.core_en;
    return w;
  endfunction

  function automatic logic [2:0] state_code(pss_state_t s);
    logic [2:0] c;
    case (s)
      ST_ASLEEP: c = 3'h1;
      ST_WAKE1: c = 3'h2;
      ST_WAKE2: c = 3'h3;
      ST_AWAKE_WAIT: c = 3'h4;
      ST_AWAKE: c = 3'h5;
      ST_SLEEP1: c = 3'h6;
      ST_SLEEP2: c = 3'h7;
      default: c = 3'h0;
    endcase
    return c;
  endfunction

endpackage

// File: verification/pss_supply_model.sv
`timescale 1ns/1ps
// ------------------------------------------------------------
// supply regulators: good follows enable after a settling lag
// ------------------------------------------------------------
module pss_supply_model (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [3:0] lag_i,
  input wire pss_pkg::pss_supply_t supply_ctrl_i,
  output pss_pkg::pss_good_t supply_good_o
);
  logic [3:0] cnt_q;
  pss_pkg::pss_supply_t last_q;
  logic settled;

  // any change of settings restarts settling of every rail
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 4'h0;
      last_q <= '0;
    end else begin
      last_q <= supply_ctrl_i;
      if (supply_ctrl_i != last_q) begin
        cnt_q <= 4'h0;
      end else if (cnt_q != 4'hF) begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign settled = (lag_i == 4'h0) ||
                   ((supply_ctrl_i == last_q) && (cnt_q >= lag_i));
  // a disabled rail never reports good
  assign supply_good_o.io_good = supply_ctrl_i.io_en && settled;
  assign supply_good_o.pll_good = supply_ctrl_i.pll_en && settled;
  assign supply_good_o.analog_good = supply_ctrl_i.analog_en && settled;
  assign supply_good_o.core_good = supply_ctrl_i.core_en && settled;
endmodule

// File: verification/power_state_supply_control_tb.sv
`timescale 1ns/1ps
module power_state_supply_control_tb;
  logic clk;
  logic rstn;
  pss_pkg::pss_reg_req_t req;
  logic [31:0] rdata;
  logic slp_req;
  logic wk_req;
  logic [31:0] cfg_a;
  logic [31:0] cfg_w1;
  logic [31:0] cfg_w2;
  pss_pkg::pss_good_t good;
  pss_pkg::pss_supply_t ctl;
  logic [2:0] code;
  logic [3:0] lag;
  int err_total;
  int n_compared;
  logic [31:0] e_aw;
  logic [31:0] e_s1;
  logic [31:0] e_s2;
  logic [31:0] d;
  int len;

  pss_power_state_ctrl pss_power_state_ctrl_inst (
    .core_clk_i(clk),
    .resetn_i(rstn),
    .reg_req_i(req),
    .reg_rdata_o(rdata),
    .sleep_req_i(slp_req),
    .wake_req_i(wk_req),
    .asleep_cfg_i(cfg_a),
    .wake1_cfg_i(cfg_w1),
    .wake2_cfg_i(cfg_w2),
    .supply_good_i(good),
    .supply_ctrl_o(ctl),
    .state_code_o(code)
  );

  pss_supply_model pss_supply_model_inst (
    .core_clk_i(clk),
    .resetn_i(rstn),
    .lag_i(lag),
    .supply_ctrl_i(ctl),
    .supply_good_o(good)
  );

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [31:0] sup(logic [31:0] w);
    return {25'h0, w[14], w[9], w[8], w[5], w[4], w[1], w[0]};
  endfunction

  function automatic logic [31:0] stat(logic [31:0] p, logic [2:0] c,
                                       logic [31:0] w);
    return {2'h0, p[5], p[4], 2'h0, p[1], p[0], 5'h0, c,
            w[15:0] & 16'h4333};
  endfunction

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results;
    $display("errors %0d comparisons %0d", err_total, n_compared);
    if (err_total == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // register bus and sequencer helpers
  // ------------------------------------------------------------
  task automatic wr(logic [7:0] a, logic [31:0] v);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= v;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  // waits for a state, checks its settings, counts its cycles
  task automatic run_len(logic [2:0] c, logic [31:0] w, output int n);
    int g;
    g = 0;
    n = 0;
    #1;
    while (code !== c && g < 400) begin
      g++;
      @(posedge clk);
      #1;
    end
    if (g == 400) begin
      err_total++;
      $display("Error state %0d expected, timed out", c);
      results();
    end
    chk("supply_ctrl_o", {25'h0, ctl}, sup(w));
    while (code === c && n < 400) begin
      n++;
      @(posedge clk);
      #1;
    end
    if (n == 400) begin
      err_total++;
      $display("Error state %0d expected to end, timed out", c);
      results();
    end
  endtask

  task automatic cycle(logic [3:0] lg, logic exact);
    logic [31:0] w;
    @(posedge clk);
    lag <= lg;
    w = $urandom;
    wr(8'h18, w);
    e_aw = (w & 32'h0000_4331) | 32'h2;
    // dwell kept to 0..7 so a run stays short
    w = $urandom & 32'hFFE7_FFFF;
    // with a settling lag the first sleep must change a rail to be held
    if (!exact) begin
      w[0] = ~e_aw[0];
    end
    wr(8'h1C, w);
    e_s1 = (w & 32'h001F_4331) | 32'h2;
    w = $urandom & 32'hFFE7_FFFF;
    wr(8'h20, w);
    e_s2 = (w & 32'h001F_4331) | 32'h2;
    cfg_a <= ($urandom & 32'h0003_4331) | 32'h2;
    cfg_w1 <= ($urandom & 32'h0003_4331) | 32'h2;
    cfg_w2 <= ($urandom & 32'h0003_4331) | 32'h2;
    rd(8'h18, d);
    chk("awake reg", d, e_aw);
    rd(8'h1C, d);
    chk("sleep1 reg", d, e_s1);
    rd(8'h20, d);
    chk("sleep2 reg", d, e_s2);
    chk("awake ctl", {25'h0, ctl}, sup(e_aw));
    @(posedge clk);
    slp_req <= 1'b1;
    @(posedge clk);
    slp_req <= 1'b0;
    run_len(3'h6, e_s1, len);
    if (exact) begin
      chk("sleep1 cycles", 32'(len), 32'h1 << e_s1[20:16]);
    end else begin
      chk("sleep1 held", {31'h0, len > int'(lg)}, 32'h1);
    end
    run_len(3'h7, e_s2, len);
    if (exact) begin
      chk("sleep2 cycles", 32'(len), 32'h1 << e_s2[20:16]);
    end
    chk("asleep state", {29'h0, code}, 32'h1);
    chk("asleep ctl", {25'h0, ctl}, sup(cfg_a));
    @(posedge clk);
    wk_req <= 1'b1;
    @(posedge clk);
    wk_req <= 1'b0;
    run_len(3'h2, cfg_w1, len);
    if (exact) begin
      chk("wake1 cycles", 32'(len), 32'h1 << cfg_w1[20:16]);
    end
    run_len(3'h3, cfg_w2, len);
    run_len(3'h4, e_aw, len);
    chk("awake state", {29'h0, code}, 32'h5);
    wr(8'h24, $urandom);
    rd(8'h24, d);
    chk("status word", d, stat(e_aw, 3'h5, e_aw));
    chk("status low", d & 32'h0000_FFFF, e_aw & 32'h4333);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    err_total = 0;
    n_compared = 0;
    rstn = 1'b0;
    req = '0;
    slp_req = 1'b0;
    wk_req = 1'b0;
    cfg_a = 32'h0000_0002;
    cfg_w1 = 32'h0000_0002;
    cfg_w2 = 32'h0000_0002;
    lag = 4'h0;
    d = $urandom(1115);
    for (int k = 0; k < 2; k++) begin
      repeat (10) @(posedge clk);
      #1;
      chk("reset ctl", {25'h0, ctl}, 32'h0);
      chk("reset state", {29'h0, code}, 32'h0);
      @(posedge clk);
      rstn <= 1'b1;
      rd(8'h18, d);
      chk("awake reset", d, 32'h0000_0033);
      rd(8'h1C, d);
      chk("sleep1 reset", d, 32'h0010_0022);
      rd(8'h20, d);
      chk("sleep2 reset", d, 32'h0010_0002);
      rd(8'h28, d);
      chk("unmapped read", d, 32'h0);
      repeat (3) cycle(4'h0, 1'b1);
      cycle(4'h8, 1'b0);
      // second pass repeats everything after a reset taken while idle in the awake state
      @(posedge clk);
      rstn <= 1'b0;
    end
    results();
  end
endmodule
